// [core/dcc_consts.svh]
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define DCC_OFS_CFG 8'h00
`define DCC_OFS_CTRL 8'h04
`define DCC_OFS_INT_STATUS 8'h08
`define DCC_OFS_INT_MASK 8'h0C
`define DCC_OFS_COUNT 8'h10

// ****************************************
// Configuration fields
// ****************************************
`define DCC_BIT_HALT 18
`define DCC_BIT_ACTIVE 17
`define DCC_BIT_LOCK 16
`define DCC_BIT_TC_EN 15
`define DCC_BIT_ERR_EN 14
`define DCC_FLOW_MSB 13
`define DCC_FLOW_LSB 11
`define DCC_FLOW_MEM2MEM 3'h0

// ****************************************
// Control, interrupt and count fields
// ****************************************
`define DCC_BIT_ENABLE 0
`define DCC_BIT_INT_TC 0
`define DCC_BIT_INT_ERR 1
`define DCC_COUNT_W 16

// ****************************************
// Reset values and sizes
// ****************************************
`define DCC_RST_WORD 32'h0000_0000
`define DCC_RST_COUNT 16'h0000
`define DCC_BURST_LEN 4
`define DCC_FIFO_DEPTH 4

`endif

// [core/dcc_pkg.sv]
package dcc_pkg;

  typedef struct packed {
    logic halt;
    logic lock;
    logic tc_en;
    logic err_en;
    logic [2:0] flow;
  } dcc_cfg_t;

  typedef enum logic [1:0] {
    DCC_IDLE = 2'b00,
    DCC_RUN = 2'b01,
    DCC_GAP = 2'b10
  } dcc_state_t;

  typedef struct packed {
    logic err;
    logic tc;
  } dcc_int_t;

endpackage

// [core/dcc_fifo.sv]
`timescale 1ns/1ns
`default_nettype none

module dcc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready,
  // Occupancy
  output logic occupied
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire empty = (wptr == rptr);
  wire full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);

  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign occupied = ~empty;
  assign out_data = mem[rptr[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

endmodule

`default_nettype wire

// [core/dcc_channel.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.svh"

module dcc_channel import dcc_pkg::*; #(
  parameter int DATA_W = 32,
  parameter int FIFO_DEPTH = `DCC_FIFO_DEPTH,
  parameter int BURST_LEN = `DCC_BURST_LEN
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral request handshake
  input wire logic periph_req,
  output logic periph_ack,
  // Source stream
  input wire logic src_valid,
  input wire logic [DATA_W-1:0] src_data,
  output logic src_ready,
  // Destination stream
  output logic dst_valid,
  output logic [DATA_W-1:0] dst_data,
  input wire logic dst_ready,
  // Bus ownership and errors
  output logic bus_req,
  output logic bus_lock,
  input wire logic xfer_err,
  // Interrupt
  output logic irq
);

  // ****************************************
  // Register state
  // ****************************************
  dcc_cfg_t cfg;
  dcc_int_t int_status;
  dcc_int_t int_mask;
  dcc_state_t state;
  dcc_state_t next_state;
  logic enable;
  logic [`DCC_COUNT_W-1:0] fetch_left;
  logic [`DCC_COUNT_W-1:0] store_left;
  logic [$clog2(BURST_LEN)-1:0] beat;

  // ****************************************
  // Bus decode
  // ****************************************
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction

  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & penable & ~pwrite;
  wire sel_cfg = hit(paddr, `DCC_OFS_CFG);
  wire sel_ctrl = hit(paddr, `DCC_OFS_CTRL);
  wire sel_ist = hit(paddr, `DCC_OFS_INT_STATUS);
  wire sel_imask = hit(paddr, `DCC_OFS_INT_MASK);
  wire sel_count = hit(paddr, `DCC_OFS_COUNT);
  wire mapped = sel_cfg | sel_ctrl | sel_ist | sel_imask | sel_count;

  // ****************************************
  // Channel FIFO
  // ****************************************
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_occ;

  dcc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(src_valid & src_ready),
    .in_data(src_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(dst_data),
    .out_ready(dst_valid & dst_ready),
    .occupied(fifo_occ)
  );

  // ****************************************
  // Transfer datapath
  // ****************************************
  // A memory-to-memory flow needs no request, so it runs as soon as it is enabled.
  wire req_ok = (cfg.flow == `DCC_FLOW_MEM2MEM) | periph_req;
  wire fetch_ok = enable & ~cfg.halt & req_ok & (fetch_left != '0);
  assign src_ready = fetch_ok & fifo_in_ready;
  assign periph_ack = src_valid & src_ready & (cfg.flow != `DCC_FLOW_MEM2MEM);
  // Draining carries on under halt so software can wait for active to fall.
  assign dst_valid = fifo_out_valid & (state == DCC_RUN);
  wire store = dst_valid & dst_ready;
  wire last_store = store & (store_left == `DCC_COUNT_W'(1));
  wire burst_end = store & (beat == ($clog2(BURST_LEN))'(BURST_LEN - 1));
  wire term_evt = last_store;
  assign bus_req = (state == DCC_RUN) & (fifo_out_valid | (cfg.lock & enable));
  assign bus_lock = (state == DCC_RUN) & cfg.lock & (enable | fifo_occ);

  always_comb begin
    next_state = state;
    case (state)
      DCC_IDLE: begin
        if (enable | fifo_occ) begin
          next_state = DCC_RUN;
        end
      end
      DCC_RUN: begin
        if (burst_end & ~cfg.lock & ~last_store) begin
          next_state = DCC_GAP;
        end else if (~enable & ~fifo_occ) begin
          next_state = DCC_IDLE;
        end
      end
      DCC_GAP: begin
        next_state = DCC_RUN;
      end
      default: begin
        next_state = DCC_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state <= DCC_IDLE;
      beat <= '0;
    end else begin
      state <= next_state;
      if (store) begin
        // Each transfer starts a fresh burst, so no count is carried over from the last one.
        beat <= (burst_end | last_store) ? '0 : beat + 1'b1;
      end
    end
  end

  // ****************************************
  // Counters
  // ****************************************
  // The count can only be loaded while the channel is stopped, so both halves stay in step.
  wire load_count = wr_en & sel_count & ~enable;

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fetch_left <= `DCC_RST_COUNT;
      store_left <= `DCC_RST_COUNT;
    end else if (load_count) begin
      fetch_left <= pwdata[`DCC_COUNT_W-1:0];
      store_left <= pwdata[`DCC_COUNT_W-1:0];
    end else begin
      if (src_valid & src_ready) begin
        fetch_left <= fetch_left - 1'b1;
      end
      if (store) begin
        store_left <= store_left - 1'b1;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cfg <= '0;
      int_mask <= '0;
      enable <= 1'b0;
    end else begin
      if (wr_en & sel_cfg) begin
        cfg.halt <= pwdata[`DCC_BIT_HALT];
        cfg.lock <= pwdata[`DCC_BIT_LOCK];
        cfg.tc_en <= pwdata[`DCC_BIT_TC_EN];
        cfg.err_en <= pwdata[`DCC_BIT_ERR_EN];
        cfg.flow <= pwdata[`DCC_FLOW_MSB:`DCC_FLOW_LSB];
      end
      if (wr_en & sel_imask) begin
        int_mask.tc <= pwdata[`DCC_BIT_INT_TC];
        int_mask.err <= pwdata[`DCC_BIT_INT_ERR];
      end
      if (last_store) begin
        enable <= 1'b0;
      end else if (wr_en & sel_ctrl) begin
        enable <= pwdata[`DCC_BIT_ENABLE];
      end
    end
  end

  // ****************************************
  // Interrupts
  // ****************************************
  wire set_tc = term_evt & cfg.tc_en;
  wire set_err = xfer_err & cfg.err_en;
  wire clr_tc = wr_en & sel_ist & pwdata[`DCC_BIT_INT_TC];
  wire clr_err = wr_en & sel_ist & pwdata[`DCC_BIT_INT_ERR];

  // An event in the clearing cycle survives because the set term is ORed in outside the clear mask.
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      int_status <= '0;
    end else begin
      int_status.tc <= set_tc | (int_status.tc & ~clr_tc);
      int_status.err <= set_err | (int_status.err & ~clr_err);
    end
  end

  assign irq = |(int_status & int_mask);

  // ****************************************
  // Read path
  // ****************************************
  wire [31:0] cfg_word = {13'h0000, cfg.halt, fifo_occ, cfg.lock, cfg.tc_en, cfg.err_en, cfg.flow,
    11'h000};
  wire [31:0] ctrl_word = {31'h0000_0000, enable};
  wire [31:0] ist_word = {30'h0000_0000, int_status.err, int_status.tc};
  wire [31:0] imask_word = {30'h0000_0000, int_mask.err, int_mask.tc};
  wire [31:0] count_word = {16'h0000, store_left};

  assign prdata = !rd_en ? `DCC_RST_WORD :
    sel_cfg ? cfg_word :
    sel_ctrl ? ctrl_word :
    sel_ist ? ist_word :
    sel_imask ? imask_word :
    sel_count ? count_word : `DCC_RST_WORD;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  sequence gap_seq;
    state == DCC_GAP ##1 state == DCC_RUN;
  endsequence

  halt_blocks_req_a: assert property (cfg.halt |-> !src_ready && !periph_ack)
    else $error("request accepted while halted");

  active_read_a: assert property (rd_en && sel_cfg |-> prdata[17] == fifo_occ)
    else $error("active bit does not follow fifo occupancy");

  active_ro_a: assert property (wr_en && sel_cfg && !(src_valid && src_ready) && !store
    |=> fifo_occ == $past(fifo_occ))
    else $error("write changed active bit");

  lock_keeps_bus_a: assert property (cfg.lock && burst_end && !last_store |=> state == DCC_RUN)
    else $error("locked channel released bus between bursts");

  unlock_gap_a: assert property (!cfg.lock && burst_end && !last_store |=> gap_seq)
    else $error("unlocked channel did not release bus after burst");

  tc_irq_set_a: assert property (term_evt && cfg.tc_en |=> int_status.tc)
    else $error("transfer end not flagged");

  tc_irq_off_a: assert property (!cfg.tc_en && !int_status.tc |=> !int_status.tc)
    else $error("transfer end flagged while disabled");

  err_irq_set_a: assert property (xfer_err && cfg.err_en
    |=> int_status.err ##0 (irq == (int_mask.err || (int_status.tc && int_mask.tc))))
    else $error("error not flagged");

  err_irq_off_a: assert property (!cfg.err_en && !int_status.err |=> !int_status.err)
    else $error("error flagged while disabled");

  mem2mem_runs_a: assert property (cfg.flow == `DCC_FLOW_MEM2MEM && fetch_ok && fifo_in_ready
    |-> src_ready && !periph_ack)
    else $error("memory flow waited for a request");

  halt_drain_a: assert property (cfg.halt && state == DCC_RUN && fifo_occ |-> dst_valid)
    else $error("halted channel does not drain");

endmodule

`default_nettype wire

// [tb/dcc_peer.sv]
`timescale 1ns/1ns
`default_nettype none
// ****
// Far side: word source, stalling sink and request line.
// ****
// The sink stalls at random so that fill and drain both get exercised.
module dcc_peer (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Bench control
  input wire logic hold,
  // Streams and request
  output logic src_valid,
  output logic [31:0] src_data,
  input wire logic src_ready,
  output logic dst_ready,
  output logic periph_req
);
  int seed = 62;
  always @(posedge mclk) begin
    if (!resetn) begin
      src_valid <= 1'b0;
      src_data <= 32'h0000_0000;
      dst_ready <= 1'b0;
      periph_req <= 1'b0;
    end else begin
      src_valid <= 1'b1;
      if (src_valid && src_ready) begin
        src_data <= $random(seed);
      end
      dst_ready <= !hold && ($random(seed) % 2 != 0);
      periph_req <= $random(seed) % 2 != 0;
    end
  end
endmodule
`default_nettype wire

// [tb/dma_channel_config_control_test.sv]
`timescale 1ns/1ns
`default_nettype none
`include "dcc_consts.svh"
module dma_channel_config_control_test;
  localparam logic [7:0] cfg_a = `DCC_OFS_CFG;
  localparam logic [7:0] ctl_a = `DCC_OFS_CTRL;
  localparam logic [7:0] sts_a = `DCC_OFS_INT_STATUS;
  localparam logic [7:0] msk_a = `DCC_OFS_INT_MASK;
  localparam logic [7:0] cnt_a = `DCC_OFS_COUNT;
  logic mclk = '0, resetn = '0, psel = '0, penable = '0, pwrite = '0, xfer_err = '0, hold = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, src_data, dst_data;
  logic pready, pslverr, periph_req, periph_ack, src_valid, src_ready, dst_valid, dst_ready;
  logic bus_req, bus_lock, irq;
  logic lock_seen = '0, lock_on = '0, burst_next = '0;
  logic [2:0] flow = '0;
  logic [31:0] rq[$];
  logic [31:0] dq[$];
  int err_count = 0, n_checks = 0, stored = 0, cyc = 0, run_n = 0;
  always #5 mclk = ~mclk;
  dcc_channel uut (.mclk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .periph_req, .periph_ack, .src_valid, .src_data, .src_ready, .dst_valid, .dst_data,
    .dst_ready, .bus_req, .bus_lock, .xfer_err, .irq);
  dcc_peer peer (.mclk, .resetn, .hold, .src_valid, .src_data, .src_ready, .dst_ready, .periph_req);
  // ****
  // Tasks.
  // ****
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic run(input logic [31:0] c, input logic [15:0] n);
    flow = c[13:11];
    lock_on = c[16];
    run_n = n;
    wr(cfg_a, c);
    stored = 0;
    wr(cnt_a, {16'h0, n});
    wr(ctl_a, 32'h1);
  endtask
  task automatic wait_st(input int n);
    while (stored < n) @(posedge mclk);
  endtask
  task automatic cki(input logic e);
    @(negedge mclk);
    chk(32'(irq), 32'(e));
  endtask
  task automatic pulse;
    @(posedge mclk);
    xfer_err <= 1'b1;
    @(posedge mclk);
    xfer_err <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ****
  // Result watcher and timeout.
  // ****
  // A word is noted when taken from the source and matched when stored.
  always @(posedge mclk) begin
    if (psel && penable && pready && !pwrite) chk(prdata, rq.pop_front());
    if (psel && penable && pready) chk(32'(pslverr), 32'(paddr > cnt_a));
    // The cycle after a full burst that is not the last shows whether the bus was kept.
    if (burst_next) chk(32'(bus_req), 32'(lock_on));
    burst_next = 1'b0;
    if (src_valid && src_ready) begin
      dq.push_back(src_data);
      chk(32'(periph_ack), 32'(flow != 3'h0));
      if (flow != 3'h0) chk(32'(periph_req), 32'h1);
    end
    if (dst_valid && dst_ready) begin
      chk(dst_data, dq.pop_front());
      stored++;
      burst_next = (stored % `DCC_BURST_LEN == 0) && (stored < run_n);
    end
    if (bus_lock) lock_seen = 1'b1;
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up;
    end
  end
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), 32'h0);
    wr(cfg_a, 32'hFFFF_FFFF);
    rd(cfg_a, 32'h0005_F800);
    $display("test reset_regs done");
    wr(msk_a, 32'h3);
    lock_seen = 1'b0;
    run(32'h0001_8000, 16'h6);
    wait_st(6);
    chk(32'(lock_seen), 32'h1);
    cki(1'b1);
    rd(sts_a, 32'h1);
    rd(ctl_a, 32'h0);
    wr(sts_a, 32'h1);
    cki(1'b0);
    $display("test lock_end done");
    hold <= 1'b1;
    lock_seen = 1'b0;
    run(32'h0, 16'h6);
    repeat (10) @(posedge mclk);
    wr(cfg_a, 32'h0004_0000);
    rd(cfg_a, 32'h0006_0000);
    hold <= 1'b0;
    wait_st(4);
    repeat (8) @(posedge mclk);
    rd(cfg_a, 32'h0004_0000);
    rd(cnt_a, 32'h2);
    wr(cfg_a, 32'h0);
    wait_st(6);
    chk(32'(lock_seen), 32'h0);
    rd(sts_a, 32'h0);
    $display("test halt_drain done");
    wr(cfg_a, 32'h0000_4000);
    pulse;
    cki(1'b1);
    rd(sts_a, 32'h2);
    wr(sts_a, 32'h2);
    wr(msk_a, 32'h1);
    pulse;
    cki(1'b0);
    wr(cfg_a, 32'h0);
    wr(sts_a, 32'h2);
    pulse;
    rd(sts_a, 32'h0);
    $display("test error_irq done");
    for (int f = 0; f < 8; f++) begin
      run({18'h0, f[2:0], 11'h0} | 32'h0000_8000, 16'h2);
      wait_st(2);
      rd(sts_a, 32'h1);
      wr(sts_a, 32'h1);
    end
    $display("test flow_codes done");
    wrap_up;
  end
endmodule
`default_nettype wire
